// ===== rtl/imcc_ctrl.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module imcc_ctrl
  import imcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic link_format_single,
  output imcc_route_t chan_route,
  output imcc_trim_t trim_cfg,
  output logic cal_hold,
  output logic div_reset,
  output logic values_clear,
  output logic fore_busy,
  output logic foreground_trim_complete
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  logic [7:0] input_routing_control_reg;
  logic [7:0] calibration_run_control_reg;
  logic [7:0] calibration_setup_primary_reg;
  logic [7:0] calibration_core_park_reg;
  logic [7:0] calibration_averaging_reg;
  logic [7:0] reg_rdata_reg;
  imcc_route_t chan_route_reg;
  imcc_route_t route_next;
  imcc_trim_t trim_cfg_reg;
  imcc_trim_t trim_next;
  logic cal_hold_reg;
  logic div_reset_reg;
  logic values_clear_reg;
  logic fore_busy_reg;
  logic complete_reg;
  logic run_bit;
  logic seq_clear;
  logic seq_fore;
  logic seq_done;

  assign run_bit = calibration_run_control_reg[RUN_BIT];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Whole bytes are kept so reserved bits read back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_routing_control_reg <= RST_ROUTE;
      calibration_run_control_reg <= RST_RUN;
      calibration_setup_primary_reg <= RST_SETUP;
      calibration_core_park_reg <= RST_PARK;
      calibration_averaging_reg <= RST_AVG;
    end else if (reg_wr) begin
      if (hit(reg_addr, ADDR_ROUTE)) begin
        input_routing_control_reg <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_RUN)) begin
        calibration_run_control_reg <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_SETUP)) begin
        calibration_setup_primary_reg <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_PARK)) begin
        calibration_core_park_reg <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_AVG)) begin
        calibration_averaging_reg <= reg_wdata;
      end
    end
  end

  // Read port: data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= RD_UNMAPPED;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ROUTE: reg_rdata_reg <= input_routing_control_reg;
        ADDR_RUN: reg_rdata_reg <= calibration_run_control_reg;
        ADDR_SETUP: reg_rdata_reg <= calibration_setup_primary_reg;
        ADDR_PARK: reg_rdata_reg <= calibration_core_park_reg;
        ADDR_AVG: reg_rdata_reg <= calibration_averaging_reg;
        ADDR_STATUS: begin
          reg_rdata_reg <= RD_UNMAPPED;
          reg_rdata_reg[STATUS_DONE_BIT] <= complete_reg;
        end
        default: reg_rdata_reg <= RD_UNMAPPED;
      endcase
    end else begin
      reg_rdata_reg <= RD_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencing
  // ----------------------------------------------------------------
  imcc_cal_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .run_en(run_bit),
    .fore_run(calibration_setup_primary_reg[SETUP_FORE_BIT]),
    .clear_pulse(seq_clear),
    .fore_busy(seq_fore),
    .done(seq_done)
  );

  // Hold and divider reset both follow the run bit; software must
  // drop the link first, this block does not police that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_hold_reg <= 1'b0;
      div_reset_reg <= 1'b0;
    end else begin
      cal_hold_reg <= !run_bit;
      div_reset_reg <= !run_bit;
    end
  end

  // Sequencer state flags, registered for clean outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      values_clear_reg <= 1'b0;
      fore_busy_reg <= 1'b0;
      complete_reg <= 1'b0;
    end else begin
      values_clear_reg <= seq_clear;
      fore_busy_reg <= seq_fore;
      complete_reg <= seq_done;
    end
  end

  // ----------------------------------------------------------------
  // Routing, taken only when a calibration starts
  // ----------------------------------------------------------------
  imcc_route u_route (
    .ctrl(input_routing_control_reg),
    .single_mode(link_format_single),
    .route(route_next)
  );

  // Latching at the clear step keeps the analog path and the trim
  // values consistent; a bare register write does nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_route_reg <= '{chan_a: SRC_A, chan_b: SRC_B};
    end else if (seq_clear) begin
      chan_route_reg <= route_next;
    end
  end

  // ----------------------------------------------------------------
  // Trim setup, also taken at the clear step
  // ----------------------------------------------------------------
  // Dependent enables are gated so the trim engine never sees an
  // offset pass without its parent pass
  always_comb begin
    trim_next.back_en = calibration_setup_primary_reg[SETUP_BACK_BIT];
    trim_next.back_ofs_en =
      calibration_setup_primary_reg[SETUP_BACK_OFS_BIT] &&
      calibration_setup_primary_reg[SETUP_BACK_BIT];
    trim_next.fore_run = calibration_setup_primary_reg[SETUP_FORE_BIT];
    trim_next.fore_ofs_en =
      calibration_setup_primary_reg[SETUP_FORE_OFS_BIT] &&
      calibration_setup_primary_reg[SETUP_FORE_BIT];
    trim_next.park_core = calibration_core_park_reg[PARK_LSB +: 2];
    // Parking only without background trim, reserved code parks none
    trim_next.park_en =
      !calibration_setup_primary_reg[SETUP_BACK_BIT] &&
      (calibration_core_park_reg[PARK_LSB +: 2] != PARK_RSVD);
    trim_next.ofs_depth = calibration_averaging_reg[AVG_OFS_LSB +: 3];
    trim_next.lin_depth = calibration_averaging_reg[AVG_LIN_LSB +: 3];
  end

  // Settings change only through a hold and rerun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_cfg_reg <= '0;
    end else if (seq_clear) begin
      trim_cfg_reg <= trim_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign chan_route = chan_route_reg;
  assign trim_cfg = trim_cfg_reg;
  assign cal_hold = cal_hold_reg;
  assign div_reset = div_reset_reg;
  assign values_clear = values_clear_reg;
  assign fore_busy = fore_busy_reg;
  assign foreground_trim_complete = complete_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int DONE_LAT = FORE_CYCLES + 2;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start_fore;
    seq_clear && run_bit && calibration_setup_primary_reg[SETUP_FORE_BIT];
  endsequence

  sequence s_start_skip;
    seq_clear && run_bit && !calibration_setup_primary_reg[SETUP_FORE_BIT];
  endsequence

  a_swap_dual: assert property (
    seq_clear && !link_format_single &&
    input_routing_control_reg[ROUTE_SWAP_BIT] |=>
    chan_route_reg.chan_a == SRC_B && chan_route_reg.chan_b == SRC_A)
    else $error("dual swap routing wrong");

  a_single_lone_a: assert property (
    seq_clear && link_format_single &&
    input_routing_control_reg[ROUTE_LONE_LSB +: 2] == LONE_A |=>
    chan_route_reg.chan_a == SRC_A && chan_route_reg.chan_b == SRC_A)
    else $error("single input A routing wrong");

  a_route_only_start: assert property (
    !seq_clear |=> $stable(chan_route_reg))
    else $error("routing moved outside calibration start");

  a_hold_follows_run: assert property (
    $fell(run_bit) |=> cal_hold_reg ##0 div_reset_reg)
    else $error("hold or divider reset missing");

  a_div_release: assert property (
    $rose(run_bit) |=> !div_reset_reg && !cal_hold_reg)
    else $error("divider reset not released");

  a_back_ofs_gate: assert property (
    trim_cfg_reg.back_ofs_en |-> trim_cfg_reg.back_en)
    else $error("background offset trim without background");

  a_fore_ofs_gate: assert property (
    trim_cfg_reg.fore_ofs_en |-> trim_cfg_reg.fore_run)
    else $error("foreground offset trim without pass");

  a_park_gate: assert property (
    trim_cfg_reg.park_en |->
    !trim_cfg_reg.back_en && trim_cfg_reg.park_core != PARK_RSVD)
    else $error("parked core enabled wrongly");

  a_depth_taken: assert property (
    seq_clear |=> trim_cfg_reg.ofs_depth ==
    $past(calibration_averaging_reg[AVG_OFS_LSB +: 3]))
    else $error("offset averaging depth not taken");

  a_skip_done: assert property (
    s_start_skip |-> ##2 complete_reg)
    else $error("skipped pass not flagged complete");

  a_fore_time: assert property (
    s_start_fore |-> ##[1:DONE_LAT] (complete_reg || !run_bit))
    else $error("foreground pass did not finish in time");

  a_fore_not_early: assert property (
    s_start_fore |=> !complete_reg [*2])
    else $error("completion flagged before pass ran");

  a_done_clears: assert property (
    !run_bit |-> ##2 !complete_reg)
    else $error("completion kept while held");

  a_rsvd_readback: assert property (
    reg_rd && reg_addr == ADDR_ROUTE |=>
    reg_rdata_reg == $past(input_routing_control_reg))
    else $error("routing register readback wrong");

endmodule

// ===== rtl/imcc_pkg.sv
package imcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the byte-wide register port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE = 8'h60;
  localparam logic [7:0] ADDR_RUN = 8'h61;
  localparam logic [7:0] ADDR_SETUP = 8'h62;
  localparam logic [7:0] ADDR_PARK = 8'h64;
  localparam logic [7:0] ADDR_AVG = 8'h68;
  localparam logic [7:0] ADDR_STATUS = 8'h6A;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ROUTE = 8'h01;
  localparam logic [7:0] RST_RUN = 8'h01;
  localparam logic [7:0] RST_SETUP = 8'h01;
  localparam logic [7:0] RST_PARK = 8'h02;
  localparam logic [7:0] RST_AVG = 8'h61;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ROUTE_SWAP_BIT = 4;
  localparam int ROUTE_LONE_LSB = 0;
  localparam int RUN_BIT = 0;
  localparam int SETUP_BACK_OFS_BIT = 3;
  localparam int SETUP_FORE_OFS_BIT = 2;
  localparam int SETUP_BACK_BIT = 1;
  localparam int SETUP_FORE_BIT = 0;
  localparam int PARK_LSB = 0;
  localparam int AVG_OFS_LSB = 4;
  localparam int AVG_LIN_LSB = 0;
  localparam int STATUS_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] LONE_RSVD = 2'h0;
  localparam logic [1:0] LONE_A = 2'h1;
  localparam logic [1:0] LONE_B = 2'h2;
  localparam logic [1:0] LONE_PAIR = 2'h3;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_A = 2'h1;
  localparam logic [1:0] SRC_B = 2'h2;
  localparam logic [1:0] PARK_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // Timing: foreground pass length
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FORE_TIME_NS = 1000;
  localparam int FORE_CYCLES =
    (FORE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FORE_CNT_W = 9;
  localparam logic [FORE_CNT_W-1:0] FORE_LAST =
    FORE_CNT_W'(FORE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] chan_a;
    logic [1:0] chan_b;
  } imcc_route_t;

  typedef struct packed {
    logic back_en;
    logic back_ofs_en;
    logic fore_run;
    logic fore_ofs_en;
    logic park_en;
    logic [1:0] park_core;
    logic [2:0] ofs_depth;
    logic [2:0] lin_depth;
  } imcc_trim_t;

  typedef enum logic [3:0] {
    SEQ_HOLD = 4'b0001,
    SEQ_CLEAR = 4'b0010,
    SEQ_FORE = 4'b0100,
    SEQ_DONE = 4'b1000
  } imcc_seq_t;

endpackage

// ===== rtl/imcc_route.sv
`timescale 1ns/1ps
module imcc_route
  import imcc_pkg::*;
(
  input wire logic [7:0] ctrl,
  input wire logic single_mode,
  output imcc_route_t route
);

  // ----------------------------------------------------------------
  // Routing decode; only swap bit and lone field matter
  // ----------------------------------------------------------------
  // Reserved bits arrive with the byte but are never decoded
  always_comb begin
    route = '{chan_a: SRC_A, chan_b: SRC_B};
    if (single_mode) begin
      // Swap bit is ignored in single-channel formats
      unique case (ctrl[ROUTE_LONE_LSB +: 2])
        LONE_A: route = '{chan_a: SRC_A, chan_b: SRC_A};
        LONE_B: route = '{chan_a: SRC_B, chan_b: SRC_B};
        LONE_PAIR: route = '{chan_a: SRC_A, chan_b: SRC_B};
        LONE_RSVD: route = '{chan_a: SRC_NONE, chan_b: SRC_NONE};
      endcase
    end else if (ctrl[ROUTE_SWAP_BIT]) begin
      // Lone field has no say here
      route = '{chan_a: SRC_B, chan_b: SRC_A};
    end
  end

endmodule

// ===== rtl/imcc_cal_seq.sv
`timescale 1ns/1ps
module imcc_cal_seq
  import imcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_en,
  input wire logic fore_run,
  output logic clear_pulse,
  output logic fore_busy,
  output logic done
);

  imcc_seq_t state_reg;
  imcc_seq_t state_next;
  logic [FORE_CNT_W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Sequencer: hold, clear values, optional foreground pass, done
  // ----------------------------------------------------------------
  // Run enable low forces hold from any state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_HOLD: begin
        if (run_en) begin
          state_next = SEQ_CLEAR;
        end
      end
      SEQ_CLEAR: begin
        // Values are cleared either way, the pass may be skipped
        state_next = fore_run ? SEQ_FORE : SEQ_DONE;
      end
      SEQ_FORE: begin
        if (cnt_reg == FORE_LAST) begin
          state_next = SEQ_DONE;
        end
      end
      SEQ_DONE: state_next = SEQ_DONE;
      default: state_next = SEQ_HOLD;
    endcase
    if (!run_en) begin
      state_next = SEQ_HOLD;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pass length counter, idle at zero outside the pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (state_reg == SEQ_FORE) begin
      cnt_reg <= cnt_reg + FORE_CNT_W'(1);
    end else begin
      cnt_reg <= '0;
    end
  end

  assign clear_pulse = (state_reg == SEQ_CLEAR);
  assign fore_busy = (state_reg == SEQ_FORE);
  assign done = (state_reg == SEQ_DONE);

endmodule

// ===== dv/imcc_ctrl_test.sv
`timescale 1ns/1ps
module imcc_ctrl_test;
  import imcc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic link_format_single = 1'b0;
  imcc_route_t chan_route;
  imcc_trim_t trim_cfg;
  logic cal_hold;
  logic div_reset;
  logic values_clear;
  logic fore_busy;
  logic foreground_trim_complete;
  int err_total = 0;
  int comparisons = 0;
  int seed = 1;
  logic rd_d = 1'b0;
  logic clr_seen = 1'b0;
  logic busy_seen = 1'b0;
  logic [7:0] exp_q[$];

  // 250 MHz clock
  always #2 clk = ~clk;

  imcc_ctrl u_imcc_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .link_format_single(link_format_single),
    .chan_route(chan_route),
    .trim_cfg(trim_cfg),
    .cal_hold(cal_hold),
    .div_reset(div_reset),
    .values_clear(values_clear),
    .fore_busy(fore_busy),
    .foreground_trim_complete(foreground_trim_complete)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_val(input string nm, input logic [13:0] e,
                         input logic [13:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read data stands only in the cycle after the strobe, so look mid-cycle
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_byte("unexpected read", 8'h00, 8'hFF);
      end else begin
        cmp_byte("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
    end else if (rst_n === 1'b1 && reg_rdata !== 8'h00) begin
      cmp_byte("reg_rdata idle", 8'h00, reg_rdata);
    end
    if (values_clear === 1'b1) clr_seen = 1'b1;
    if (fore_busy === 1'b1) busy_seen = 1'b1;
  end

  // ----------------------------------------------------------------
  // Register port cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Drop the run bit, check the hold, then rerun; n counts cycles to done
  // The serial link is never enabled here, so the run bit may move freely
  task automatic recal(output int n);
    wr(ADDR_RUN, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    cmp_val("cal_hold", 14'h1, {13'h0, cal_hold});
    cmp_val("div_reset", 14'h1, {13'h0, div_reset});
    cmp_val("done low", 14'h0, {13'h0, foreground_trim_complete});
    clr_seen = 1'b0;
    busy_seen = 1'b0;
    wr(ADDR_RUN, 8'h01);
    n = 0;
    while (foreground_trim_complete !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_val("done bound", 14'h1, {13'h0, n < 400});
    cmp_val("values_clear", 14'h1, {13'h0, clr_seen});
    cmp_val("cal_hold run", 14'h0, {13'h0, cal_hold});
    cmp_val("div_reset run", 14'h0, {13'h0, div_reset});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] addrs [5];
    logic [7:0] rsts [5];
    logic [7:0] r;
    logic [7:0] a;
    logic [1:0] p;
    imcc_route_t er;
    imcc_route_t mr;
    imcc_trim_t et;
    imcc_trim_t mt;
    int n;
    addrs = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h68};
    rsts = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h61};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped place and read-only status
    for (int i = 0; i < 5; i++) rd(addrs[i], rsts[i]);
    wr(8'h63, 8'hFF);
    rd(8'h63, 8'h00);
    n = 0;
    while (foreground_trim_complete !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_val("route reset", 14'h0006, {10'h0, chan_route});
    cmp_val("trim reset", 14'h05B1, {1'b0, trim_cfg});
    wr(ADDR_STATUS, 8'hFE);
    rd(ADDR_STATUS, 8'h01);
    // Every byte, reserved bits included, is stored and read back
    for (int i = 0; i < 5; i++) begin
      r = 8'($random(seed));
      if (i == 1) r[0] = 1'b1;
      wr(addrs[i], r);
      rd(addrs[i], r);
    end
    wr(ADDR_SETUP, 8'h00);
    // Routing: every format, swap and lone code, with noise in reserved bits
    for (int k = 0; k < 16; k++) begin
      r = 8'($random(seed));
      link_format_single <= k[3];
      wr(ADDR_ROUTE, {r[7:5], k[2], r[3:2], k[1:0]});
      recal(n);
      mr = '1;
      if (k[3] == 1'b0) begin
        er = k[2] ? {SRC_B, SRC_A} : {SRC_A, SRC_B};
      end else begin
        case (k[1:0])
          2'h0: er = {SRC_NONE, SRC_NONE};
          2'h1: er = {SRC_A, SRC_A};
          2'h2: er = {SRC_B, SRC_B};
          default: er = {SRC_A, SRC_B};
        endcase
        if (k[1:0] == 2'h1 || k[1:0] == 2'h2) mr.chan_b = 2'h0;
      end
      cmp_val("route", {10'h0, er & mr}, {10'h0, chan_route & mr});
      // A new setting must not move the routing before a rerun
      wr(ADDR_ROUTE, {3'h0, ~k[2], 2'h0, k[1:0] ^ 2'h3});
      repeat (3) @(posedge clk);
      #1;
      cmp_val("route held", {10'h0, er & mr}, {10'h0, chan_route & mr});
    end
    link_format_single <= 1'b0;
    wr(ADDR_ROUTE, 8'h01);
    // Trim setup: every enable combination, park codes, random depths
    for (int k = 0; k < 16; k++) begin
      r = 8'($random(seed));
      a = 8'($random(seed));
      p = k[1:0] + k[3:2];
      wr(ADDR_SETUP, {r[7:4], 4'(k)});
      wr(ADDR_PARK, {r[7:2], p});
      wr(ADDR_AVG, a);
      recal(n);
      et.back_en = k[1];
      et.back_ofs_en = k[3] & k[1];
      et.fore_run = k[0];
      et.fore_ofs_en = k[2] & k[0];
      et.park_en = !k[1] && p != PARK_RSVD;
      et.park_core = p;
      et.ofs_depth = a[6:4];
      et.lin_depth = a[2:0];
      mt = '1;
      if (!et.park_en) mt.park_core = 2'h0;
      cmp_val("trim", {1'b0, et & mt}, {1'b0, trim_cfg & mt});
      cmp_val("busy seen", {13'h0, k[0]}, {13'h0, busy_seen});
      if (k[0]) begin
        cmp_val("pass length", 14'h1, {13'h0, n >= FORE_CYCLES});
      end else begin
        cmp_val("skip length", 14'h1, {13'h0, n <= 8});
      end
      cmp_val("busy after", 14'h0, {13'h0, fore_busy});
    end
    close_out();
  end

  // Watchdog well past the roughly 3k cycles the sequence needs
  initial begin
    #(4 * 60000);
    $display("[ERR] watchdog expected done seen hang");
    err_total++;
    close_out();
  end
endmodule
